// [hw/chan_if.sv]
// Configuration and status bundle between register file and one counter channel
`timescale 1ns/1ps
`default_nettype none
interface chan_if #(parameter int CNT_W = 32, parameter int PDIV_W = 8);
   logic fall;
   logic gate_high;
   logic gate_use;
   logic limit_en;
   logic run;
   logic clear;
   logic [PDIV_W-1:0] pdiv;
   logic [CNT_W-1:0] limit;
   logic [CNT_W-1:0] count;
   logic wrap;
   modport ctl (output fall, gate_high, gate_use, limit_en, run, clear, pdiv, limit, input count, wrap);
   modport chan (input fall, gate_high, gate_use, limit_en, run, clear, pdiv, limit, output count, wrap);
endinterface
`default_nettype wire

// [hw/counter_channel.sv]
// One gated, pre-divided, up-only event counter channel
`timescale 1ns/1ps
`default_nettype none
module counter_channel #(
   parameter int CNT_W = 32,
   parameter int PDIV_W = 8
) (
   input wire logic sys_clk_i, // Module clock
   input wire logic rst_n_i,   // Asynchronous reset, active low
   input wire logic count_in_i, // Pulse input
   input wire logic gate_in_i,  // Gate input
   chan_if.chan bus            // Settings in, count out
);
   logic prev_r, prev_nxt;
   logic [PDIV_W-1:0] pdiv_cnt_r, pdiv_cnt_nxt;
   logic [CNT_W-1:0] count_r, count_nxt;
   logic wrap_r, wrap_nxt;
   logic edge_hit, gate_ok, active, advance;

   always_comb
   begin
      edge_hit = bus.fall ? (prev_r & ~count_in_i) : (~prev_r & count_in_i);
      gate_ok = !bus.gate_use || (gate_in_i == bus.gate_high);
      active = bus.run && gate_ok;
      advance = active && edge_hit && (pdiv_cnt_r >= bus.pdiv);
      prev_nxt = count_in_i;
      pdiv_cnt_nxt = pdiv_cnt_r;
      count_nxt = count_r;
      wrap_nxt = 1'b0;
      if (bus.clear)
      begin
         pdiv_cnt_nxt = '0;
         count_nxt = '0;
      end
      else if (active && edge_hit)
      begin
         pdiv_cnt_nxt = advance ? '0 : pdiv_cnt_r + PDIV_W'(1);
         if (advance)
         begin
            if (bus.limit_en && count_r >= bus.limit)
            begin
               count_nxt = '0;
               wrap_nxt = 1'b1;
            end
            else
               count_nxt = count_r + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prev_r <= 1'b0;
         pdiv_cnt_r <= '0;
         count_r <= '0;
         wrap_r <= 1'b0;
      end
      else
      begin
         prev_r <= prev_nxt;
         pdiv_cnt_r <= pdiv_cnt_nxt;
         count_r <= count_nxt;
         wrap_r <= wrap_nxt;
      end
   end

   assign bus.count = count_r;
   assign bus.wrap = wrap_r;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_stopped_clear;
      !bus.run ##1 bus.clear;
   endsequence

   a_reset_zero: assert property (disable iff (1'b0) !rst_n_i |-> count_r == '0) else $error("count not zero in reset");
   a_count_up_only: assert property ($changed(count_r) |-> count_r == $past(count_r) + CNT_W'(1) || count_r == '0)
      else $error("count moved other than up or to zero");
   a_stop_freezes: assert property (!bus.run && !bus.clear |=> $stable(count_r)) else $error("stopped channel counted");
   a_gate_blocks: assert property (bus.gate_use && gate_in_i != bus.gate_high && !bus.clear |=> $stable(count_r) && $stable(pdiv_cnt_r))
      else $error("closed gate let a pulse through");
   a_edge_needed: assert property (!edge_hit && !bus.clear |=> $stable(count_r)) else $error("count without selected edge");
   a_prediv_step: assert property (active && edge_hit && !bus.clear && pdiv_cnt_r < bus.pdiv
      |=> $stable(count_r) && pdiv_cnt_r == $past(pdiv_cnt_r) + PDIV_W'(1)) else $error("pre-divider skipped");
   a_wrap_zero: assert property (advance && bus.limit_en && count_r >= bus.limit && !bus.clear |=> wrap_r && count_r == '0)
      else $error("limit overrun without wrap");
   a_clear_seq: assert property (s_stopped_clear |=> count_r == '0 ##1 count_r == '0) else $error("clear did not zero count");
endmodule
`default_nettype wire

// [hw/dual_gated_event_counter.sv]
// Two gated event counters behind an AXI4-Lite register slave
// Notes on behaviour
// - Two counter channels, each with its own pulse input and gate input.
// - One channel's activity or settings never affect the other channel.
// - Per channel, choose rising or falling pulse edge; only that edge counts.
// - Per channel, choose gate active low or high; count only while active.
// - Pulses pass an 8-bit pre-divider, setting 0 to 255, before counting.
// - Passing the enabled upper limit sets a flag and restarts count at zero.
// - Both counts are zero after reset, before any pulse.
// - Counting is upward only; no down mode exists.
// - Gate or software enable starts and stops a channel; stop code stops it.
`timescale 1ns/1ps
`default_nettype none
module dual_gated_event_counter #(
   parameter int CNT_W = evcnt_pkg::CNT_W_DEF,
   parameter int PDIV_W = evcnt_pkg::PDIV_W_DEF
) (
   input wire logic sys_clk_i, // Module clock, 40 MHz
   input wire logic rst_n_i,   // Asynchronous reset, active low
   input wire logic [evcnt_pkg::N_CHAN-1:0] count_in_i, // Pulse inputs, bit 0 is counter A
   input wire logic [evcnt_pkg::N_CHAN-1:0] gate_in_i,  // Gate inputs, bit 0 is counter A
   input wire logic [evcnt_pkg::ADDR_W-1:0] s_axi_awaddr_i, // Write address
   input wire logic s_axi_awvalid_i, // Write address valid
   output logic s_axi_awready_o,     // Write address ready
   input wire logic [31:0] s_axi_wdata_i, // Write data
   input wire logic [3:0] s_axi_wstrb_i,  // Write byte strobes
   input wire logic s_axi_wvalid_i,  // Write data valid
   output logic s_axi_wready_o,      // Write data ready
   output logic [1:0] s_axi_bresp_o, // Write response
   output logic s_axi_bvalid_o,      // Write response valid
   input wire logic s_axi_bready_i,  // Write response ready
   input wire logic [evcnt_pkg::ADDR_W-1:0] s_axi_araddr_i, // Read address
   input wire logic s_axi_arvalid_i, // Read address valid
   output logic s_axi_arready_o,     // Read address ready
   output logic [31:0] s_axi_rdata_o, // Read data
   output logic [1:0] s_axi_rresp_o, // Read response
   output logic s_axi_rvalid_o,      // Read data valid
   input wire logic s_axi_rready_i,  // Read data ready
   output logic irq_o                // Interrupt level, high while unmasked wrap flag set
);
   localparam int NC = evcnt_pkg::N_CHAN;

   if (CNT_W < 1 || CNT_W > 32)
      $error("CNT_W must be 1 to 32");
   if (PDIV_W < 1 || PDIV_W > 16)
      $error("PDIV_W must be 1 to 16");

   function automatic logic mapped(input logic [evcnt_pkg::ADDR_W-1:0] a);
      logic [7:0] off;
      off = a & (evcnt_pkg::BANK_STRIDE - 8'h01);
      if (a[1:0] != 2'h0)
         return 1'b0;
      if (a == evcnt_pkg::OFF_IRQ_STAT || a == evcnt_pkg::OFF_IRQ_MASK)
         return 1'b1;
      return a < evcnt_pkg::OFF_IRQ_STAT && off <= evcnt_pkg::OFF_COUNT;
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[8*b +: 8] = nw[8*b +: 8];
      return r;
   endfunction

   evcnt_pkg::wr_state_e wst_r, wst_nxt;
   evcnt_pkg::rd_state_e rst_r, rst_nxt;
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [evcnt_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [evcnt_pkg::CFG_W-1:0] cfg_r [NC], cfg_nxt [NC];
   logic [NC-1:0] run_r, run_nxt, clear_r, clear_nxt;
   logic [PDIV_W-1:0] pdiv_r [NC], pdiv_nxt [NC];
   logic [CNT_W-1:0] limit_r [NC], limit_nxt [NC];
   logic [CNT_W-1:0] cnt_w [NC];
   logic [NC-1:0] wrap_w, stat_r, stat_nxt, mask_r, mask_nxt;
   logic irq_r, irq_nxt;
   logic aw_hit, w_hit, do_wr, ar_hit;
   logic [evcnt_pkg::ADDR_W-1:0] waddr;
   logic [31:0] wd, wmask;
   logic [3:0] ws;
   logic [7:0] woff, roff;

   chan_if #(.CNT_W(CNT_W), .PDIV_W(PDIV_W)) ch [NC] ();

   for (genvar g = 0; g < NC; g++)
   begin : g_chan
      assign ch[g].fall = cfg_r[g][evcnt_pkg::CFG_FALL_BIT];
      assign ch[g].gate_high = cfg_r[g][evcnt_pkg::CFG_GATE_HIGH_BIT];
      assign ch[g].gate_use = cfg_r[g][evcnt_pkg::CFG_GATE_USE_BIT];
      assign ch[g].limit_en = cfg_r[g][evcnt_pkg::CFG_LIMIT_EN_BIT];
      assign ch[g].run = run_r[g];
      assign ch[g].clear = clear_r[g];
      assign ch[g].pdiv = pdiv_r[g];
      assign ch[g].limit = limit_r[g];
      assign cnt_w[g] = ch[g].count;
      assign wrap_w[g] = ch[g].wrap;
      // Each channel has private inputs and settings
      counter_channel #(.CNT_W(CNT_W), .PDIV_W(PDIV_W)) u_chan (
         .sys_clk_i(sys_clk_i),
         .rst_n_i(rst_n_i),
         .count_in_i(count_in_i[g]),
         .gate_in_i(gate_in_i[g]),
         .bus(ch[g].chan)
      );
   end

   assign s_axi_awready_o = (wst_r == evcnt_pkg::W_IDLE) && !aw_have_r;
   assign s_axi_wready_o = (wst_r == evcnt_pkg::W_IDLE) && !w_have_r;
   assign s_axi_bvalid_o = (wst_r == evcnt_pkg::W_RESP);
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_arready_o = (rst_r == evcnt_pkg::R_IDLE);
   assign s_axi_rvalid_o = (rst_r == evcnt_pkg::R_DATA);
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;
   assign irq_o = irq_r;

   always_comb
   begin
      aw_hit = s_axi_awvalid_i && s_axi_awready_o;
      w_hit = s_axi_wvalid_i && s_axi_wready_o;
      waddr = aw_have_r ? awaddr_r : s_axi_awaddr_i;
      wd = w_have_r ? wdata_r : s_axi_wdata_i;
      ws = w_have_r ? wstrb_r : s_axi_wstrb_i;
      woff = waddr & (evcnt_pkg::BANK_STRIDE - 8'h01);
      wmask = wmerge(32'h0, 32'hffffffff, ws);
      do_wr = (wst_r == evcnt_pkg::W_IDLE) && (aw_have_r || aw_hit) && (w_have_r || w_hit);
      wst_nxt = wst_r;
      aw_have_nxt = aw_have_r || aw_hit;
      w_have_nxt = w_have_r || w_hit;
      awaddr_nxt = aw_hit ? s_axi_awaddr_i : awaddr_r;
      wdata_nxt = w_hit ? s_axi_wdata_i : wdata_r;
      wstrb_nxt = w_hit ? s_axi_wstrb_i : wstrb_r;
      bresp_nxt = bresp_r;
      cfg_nxt = cfg_r;
      run_nxt = run_r;
      pdiv_nxt = pdiv_r;
      limit_nxt = limit_r;
      clear_nxt = '0;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      if (do_wr)
      begin
         wst_nxt = evcnt_pkg::W_RESP;
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bresp_nxt = mapped(waddr) ? evcnt_pkg::RESP_OKAY : evcnt_pkg::RESP_SLVERR;
         if (waddr == evcnt_pkg::OFF_IRQ_STAT)
            stat_nxt = stat_r & ~(NC'(wd & wmask));
         if (waddr == evcnt_pkg::OFF_IRQ_MASK)
            mask_nxt = NC'(wmerge(32'(mask_r), wd, ws));
         for (int c = 0; c < NC; c++)
         begin
            if (mapped(waddr) && waddr < evcnt_pkg::OFF_IRQ_STAT && int'(waddr[5]) == c)
            begin
               if (woff == evcnt_pkg::OFF_CFG)
                  cfg_nxt[c] = evcnt_pkg::CFG_W'(wmerge(32'(cfg_r[c]), wd, ws));
               if (woff == evcnt_pkg::OFF_CMD && ws[0] && wd[7:0] == evcnt_pkg::CMD_CLEAR)
                  clear_nxt[c] = 1'b1;
               if (woff == evcnt_pkg::OFF_EN && ws[0] && wd[7:0] == evcnt_pkg::EN_START)
                  run_nxt[c] = 1'b1;
               if (woff == evcnt_pkg::OFF_EN && ws[0] && wd[7:0] == evcnt_pkg::EN_STOP)
                  run_nxt[c] = 1'b0;
               if (woff == evcnt_pkg::OFF_PDIV)
                  pdiv_nxt[c] = PDIV_W'(wmerge(32'(pdiv_r[c]), wd, ws));
               if (woff == evcnt_pkg::OFF_LIMIT)
                  limit_nxt[c] = CNT_W'(wmerge(32'(limit_r[c]), wd, ws));
            end
         end
      end
      else if (wst_r == evcnt_pkg::W_RESP && s_axi_bready_i)
         wst_nxt = evcnt_pkg::W_IDLE;
      // A wrap in the same cycle as its clear keeps the flag set
      stat_nxt = stat_nxt | wrap_w;
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   always_comb
   begin
      ar_hit = s_axi_arvalid_i && s_axi_arready_o;
      roff = s_axi_araddr_i & (evcnt_pkg::BANK_STRIDE - 8'h01);
      rst_nxt = rst_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (ar_hit)
      begin
         rst_nxt = evcnt_pkg::R_DATA;
         rdata_nxt = 32'h0;
         rresp_nxt = mapped(s_axi_araddr_i) ? evcnt_pkg::RESP_OKAY : evcnt_pkg::RESP_SLVERR;
         if (s_axi_araddr_i == evcnt_pkg::OFF_IRQ_STAT)
            rdata_nxt = 32'(stat_r);
         else if (s_axi_araddr_i == evcnt_pkg::OFF_IRQ_MASK)
            rdata_nxt = 32'(mask_r);
         else if (mapped(s_axi_araddr_i))
         begin
            for (int c = 0; c < NC; c++)
            begin
               if (int'(s_axi_araddr_i[5]) == c)
               begin
                  if (roff == evcnt_pkg::OFF_CFG)
                     rdata_nxt = 32'(cfg_r[c]);
                  else if (roff == evcnt_pkg::OFF_EN)
                     rdata_nxt = 32'(run_r[c]);
                  else if (roff == evcnt_pkg::OFF_PDIV)
                     rdata_nxt = 32'(pdiv_r[c]);
                  else if (roff == evcnt_pkg::OFF_LIMIT)
                     rdata_nxt = 32'(limit_r[c]);
                  else if (roff == evcnt_pkg::OFF_COUNT)
                     rdata_nxt = 32'(cnt_w[c]);
               end
            end
         end
      end
      else if (rst_r == evcnt_pkg::R_DATA && s_axi_rready_i)
         rst_nxt = evcnt_pkg::R_IDLE;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wst_r <= evcnt_pkg::W_IDLE;
         rst_r <= evcnt_pkg::R_IDLE;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         bresp_r <= evcnt_pkg::RESP_OKAY;
         rresp_r <= evcnt_pkg::RESP_OKAY;
         rdata_r <= 32'h0;
         for (int c = 0; c < NC; c++)
         begin
            cfg_r[c] <= evcnt_pkg::CFG_RST;
            pdiv_r[c] <= '0;
            limit_r[c] <= CNT_W'(evcnt_pkg::LIMIT_RST);
         end
         run_r <= '0;
         clear_r <= '0;
         stat_r <= '0;
         mask_r <= '0;
         irq_r <= 1'b0;
      end
      else
      begin
         wst_r <= wst_nxt;
         rst_r <= rst_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bresp_r <= bresp_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         cfg_r <= cfg_nxt;
         pdiv_r <= pdiv_nxt;
         limit_r <= limit_nxt;
         run_r <= run_nxt;
         clear_r <= clear_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_stop_a;
      do_wr && waddr == evcnt_pkg::OFF_EN && ws[0] && wd[7:0] == evcnt_pkg::EN_STOP;
   endsequence

   a_wrap_flags: assert property ((|wrap_w) |=> (stat_r & $past(wrap_w)) == $past(wrap_w))
      else $error("wrap flag lost");
   a_chan_indep: assert property (do_wr && waddr < evcnt_pkg::BANK_STRIDE |=> $stable(cfg_r[1]) && $stable(run_r[1])
      && $stable(limit_r[1])) else $error("write to A changed B");
   a_stop_code: assert property (s_stop_a |=> !run_r[0] && s_axi_bvalid_o) else $error("stop code ignored");
   a_read_count: assert property (ar_hit && s_axi_araddr_i == evcnt_pkg::OFF_COUNT |=> s_axi_rvalid_o
      && s_axi_rdata_o == 32'($past(cnt_w[0]))) else $error("count read mismatch");
endmodule
`default_nettype wire

// [hw/evcnt_pkg.sv]
// Shared constants and types for the dual gated event counter
`default_nettype none
package evcnt_pkg;
   localparam int N_CHAN = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W_DEF = 32;
   localparam int PDIV_W_DEF = 8;
   // Register map, byte addresses; channel banks repeat at BANK_STRIDE
   localparam logic [7:0] BANK_STRIDE = 8'h20;
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_EN = 8'h08;
   localparam logic [7:0] OFF_PDIV = 8'h0c;
   localparam logic [7:0] OFF_LIMIT = 8'h10;
   localparam logic [7:0] OFF_COUNT = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h40;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
   // Configuration fields
   localparam int CFG_FALL_BIT = 0;
   localparam int CFG_GATE_HIGH_BIT = 1;
   localparam int CFG_GATE_USE_BIT = 2;
   localparam int CFG_LIMIT_EN_BIT = 3;
   localparam int CFG_W = 4;
   // Command and enable codes
   localparam logic [7:0] CMD_CLEAR = 8'h01;
   localparam logic [7:0] EN_START = 8'h01;
   localparam logic [7:0] EN_STOP = 8'h02;
   // Reset values, response codes and state encodings
   localparam logic [3:0] CFG_RST = 4'h0;
   localparam logic [31:0] LIMIT_RST = 32'hffffffff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {W_IDLE = 2'b01, W_RESP = 2'b10} wr_state_e;
   typedef enum logic [1:0] {R_IDLE = 2'b01, R_DATA = 2'b10} rd_state_e;
endpackage
`default_nettype wire

// [testbench/pulse_source.sv]
// Field-side model: pulse bursts and gate levels on both counter inputs
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
   input wire logic sys_clk_i, // Clock
   input wire logic rst_n_i, // Reset, active low
   input wire logic [1:0] go_i, // Start a burst per channel
   input wire logic [8:0] num_i, // Pulses in the burst
   input wire logic [1:0] idle_i, // Resting level of each pulse line
   input wire logic [1:0] gate_lvl_i, // Gate level per channel
   output logic [1:0] pulse_o, // Pulse lines
   output logic [1:0] gate_o, // Gate lines
   output logic [1:0] busy_o // Burst running
);
   logic [8:0] left_r [2];
   logic [1:0] ph_r [2];
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      for (int c = 0; c < 2; c++)
      begin
         if (!rst_n_i)
         begin
            left_r[c] <= 9'h000;
            ph_r[c] <= 2'h0;
         end
         else if (go_i[c])
         begin
            left_r[c] <= num_i;
            ph_r[c] <= 2'h0;
         end
         else if (left_r[c] != 9'h000)
         begin
            ph_r[c] <= ph_r[c] + 2'h1;
            if (ph_r[c] == 2'h3)
               left_r[c] <= left_r[c] - 9'h001;
         end
      end
   end
   // Each level is held two cycles, so counted edges never come closer than the counter accepts
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         busy_o[c] = left_r[c] != 9'h000;
         pulse_o[c] = idle_i[c] ^ (busy_o[c] && !ph_r[c][1]);
      end
      gate_o = gate_lvl_i;
   end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the dual gated event counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r, go, idle, gate_lvl, pulse, gate, busy;
   logic [8:0] num;
   int failures, checked, cycles;

   always #12.5 sys_clk = ~sys_clk;

   dual_gated_event_counter DUT (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .count_in_i(pulse), .gate_in_i(gate),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .irq_o(irq));
   pulse_source field (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .go_i(go), .num_i(num), .idle_i(idle),
      .gate_lvl_i(gate_lvl), .pulse_o(pulse), .gate_o(gate), .busy_o(busy));

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] adr(input int c, input logic [7:0] off);
      return evcnt_pkg::BANK_STRIDE * 8'(c) + off;
   endfunction

   // Ready is looked at on the falling edge, so the handshake edge that follows is known
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw_t, w_t, b_t;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(negedge sys_clk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         @(posedge sys_clk);
         if (aw_t)
            awvalid <= 1'b0;
         if (w_t)
            wvalid <= 1'b0;
      end while ((awvalid && !aw_t) || (wvalid && !w_t));
      bready <= 1'b1;
      do
      begin
         @(negedge sys_clk);
         b_t = bvalid;
         r = bresp;
         @(posedge sys_clk);
      end while (!b_t);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      logic t;
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(negedge sys_clk);
         t = arready;
         @(posedge sys_clk);
      end while (!t);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do
      begin
         @(negedge sys_clk);
         t = rvalid;
         d = rdata;
         r = rresp;
         @(posedge sys_clk);
      end while (!t);
      rready <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
   endtask

   task automatic cnt_is(input int c, input logic [31:0] e);
      rdc(adr(c, evcnt_pkg::OFF_COUNT), e);
   endtask

   // A burst of zero pulses only lets the inputs settle
   task automatic burst(input int c, input logic [8:0] n);
      num <= n;
      go[c] <= 1'b1;
      @(posedge sys_clk);
      go[c] <= 1'b0;
      @(negedge sys_clk);
      while (busy[c])
         @(negedge sys_clk);
      repeat (4) @(posedge sys_clk);
   endtask

   initial
   begin
      {sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
      {awaddr, araddr, wdata, num, go, idle, gate_lvl} = 63'h0;
      {failures, checked, cycles} = {32'h0, 32'h0, 32'h0};
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      cnt_is(0, 32'h0);
      cnt_is(1, 32'h0);
      rdc(adr(0, evcnt_pkg::OFF_LIMIT), evcnt_pkg::LIMIT_RST);
      rdc(adr(1, evcnt_pkg::OFF_CFG), 32'h0);
      rd(8'h80);
      chk({30'h0, r}, {30'h0, evcnt_pkg::RESP_SLVERR});
      chk(d, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(8'h80, 32'h1);
      chk({30'h0, r}, {30'h0, evcnt_pkg::RESP_SLVERR});
      $display("test reset done");
      wr(adr(0, evcnt_pkg::OFF_EN), {24'h0, evcnt_pkg::EN_START});
      chk({30'h0, r}, {30'h0, evcnt_pkg::RESP_OKAY});
      rdc(adr(0, evcnt_pkg::OFF_EN), 32'h1);
      // B runs on a quiet input, so any leak of A's pulses would show in its count
      wr(adr(1, evcnt_pkg::OFF_EN), {24'h0, evcnt_pkg::EN_START});
      burst(0, 9'h005);
      cnt_is(0, 32'h5);
      cnt_is(1, 32'h0);
      fork
         burst(0, 9'h005);
         rd(adr(0, evcnt_pkg::OFF_COUNT));
      join
      cnt_is(0, 32'ha);
      $display("test rising edge done");
      wr(adr(1, evcnt_pkg::OFF_CFG), 32'h1);
      wr(adr(1, evcnt_pkg::OFF_EN), {24'h0, evcnt_pkg::EN_START});
      idle[1] <= 1'b1;
      burst(1, 9'h000);
      cnt_is(1, 32'h0);
      burst(1, 9'h004);
      cnt_is(1, 32'h4);
      idle[1] <= 1'b0;
      burst(1, 9'h000);
      cnt_is(1, 32'h5);
      cnt_is(0, 32'ha);
      $display("test falling edge done");
      wr(adr(0, evcnt_pkg::OFF_CFG), 32'h6);
      burst(0, 9'h003);
      cnt_is(0, 32'ha);
      gate_lvl[0] <= 1'b1;
      burst(0, 9'h003);
      cnt_is(0, 32'hd);
      wr(adr(0, evcnt_pkg::OFF_CFG), 32'h4);
      burst(0, 9'h002);
      cnt_is(0, 32'hd);
      gate_lvl[0] <= 1'b0;
      burst(0, 9'h002);
      cnt_is(0, 32'hf);
      $display("test gate done");
      wr(adr(0, evcnt_pkg::OFF_EN), {24'h0, evcnt_pkg::EN_STOP});
      rdc(adr(0, evcnt_pkg::OFF_EN), 32'h0);
      burst(0, 9'h002);
      cnt_is(0, 32'hf);
      wr(adr(0, evcnt_pkg::OFF_CMD), {24'h0, evcnt_pkg::CMD_CLEAR});
      cnt_is(0, 32'h0);
      wr(adr(0, evcnt_pkg::OFF_CFG), 32'h0);
      wr(adr(0, evcnt_pkg::OFF_PDIV), 32'h2);
      wr(adr(0, evcnt_pkg::OFF_EN), {24'h0, evcnt_pkg::EN_START});
      burst(0, 9'h006);
      cnt_is(0, 32'h2);
      wr(adr(0, evcnt_pkg::OFF_PDIV), 32'hff);
      burst(0, 9'h0ff);
      cnt_is(0, 32'h2);
      burst(0, 9'h001);
      cnt_is(0, 32'h3);
      $display("test stop clear divide done");
      wr(adr(1, evcnt_pkg::OFF_CFG), 32'h8);
      wr(adr(1, evcnt_pkg::OFF_LIMIT), 32'h3);
      wr(adr(1, evcnt_pkg::OFF_EN), {24'h0, evcnt_pkg::EN_STOP});
      wr(adr(1, evcnt_pkg::OFF_CMD), {24'h0, evcnt_pkg::CMD_CLEAR});
      wr(adr(1, evcnt_pkg::OFF_EN), {24'h0, evcnt_pkg::EN_START});
      burst(1, 9'h005);
      cnt_is(1, 32'h1);
      rdc(evcnt_pkg::OFF_IRQ_STAT, 32'h2);
      chk({31'h0, irq}, 32'h0);
      wr(evcnt_pkg::OFF_IRQ_MASK, 32'h2);
      burst(1, 9'h000);
      chk({31'h0, irq}, 32'h1);
      wr(evcnt_pkg::OFF_IRQ_STAT, 32'h2);
      burst(1, 9'h000);
      chk({31'h0, irq}, 32'h0);
      rdc(evcnt_pkg::OFF_IRQ_STAT, 32'h0);
      cnt_is(0, 32'h3);
      $display("test limit done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
